//--- nap_pkg.sv
// Constants, types and decoding shared by the nibble datapath files.
// Assumes one clock domain and ten-bit instruction words.
package nap_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int INSTR_W = 10;
  localparam int NIB_W = 4;
  localparam int ROM_ADDR_W = 10;
  localparam int NUM_REGS = 16;
  localparam int NUM_PORT_SLOTS = 8;
  localparam int PORT_BITS = NUM_PORT_SLOTS * NIB_W;

  // ----------------------------------------------------------------
  // Field positions inside the first instruction word
  // ----------------------------------------------------------------
  localparam int BANK_BIT = 5;
  localparam int HL_BIT = 5;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [3:0] ACC_RST = 4'h0;
  localparam logic CARRY_RST = 1'b0;
  localparam logic [3:0] NIB_RST = 4'h0;
  localparam logic [9:0] WORD_RST = 10'h000;

  // ----------------------------------------------------------------
  // Operations and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NONE, OP_OR_REG, OP_OR_ROM, OP_OR_IMM, OP_XOR_REG, OP_XOR_ROM, OP_XOR_IMM,
    OP_INC, OP_ROT, OP_ROT_ZRST, OP_PORT_IN, OP_PORT_OUT, OP_PORT_AND, OP_PORT_OR,
    OP_PORT_XOR, OP_PORT_IMM, OP_A_FROM_REG, OP_A_FROM_ROM, OP_A_FROM_IMM,
    OP_REG_FROM_A, OP_REG_FROM_IMM
  } nap_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_OPER = 2'b10
  } nap_state_t;

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  // Fixed codes are matched before the register forms they overlap
  function automatic nap_op_t nap_decode(input logic [INSTR_W-1:0] w);
    nap_op_t op;
    op = OP_NONE;
    casez (w)
      10'b1110110001: op = OP_OR_IMM;
      10'b1110?10000: op = OP_OR_ROM;
      10'b1110?11???: op = OP_PORT_OR;
      10'b1110?0????: op = OP_OR_REG;
      10'b1010110001: op = OP_XOR_IMM;
      10'b1010010011: op = OP_INC;
      10'b1010?10000: op = OP_XOR_ROM;
      10'b1010?11???: op = OP_PORT_XOR;
      10'b1010?0????: op = OP_XOR_REG;
      10'b1111110011: op = OP_ROT;
      10'b1111010011: op = OP_ROT_ZRST;
      10'b1111110001: op = OP_A_FROM_IMM;
      10'b1111?10000: op = OP_A_FROM_ROM;
      10'b1111?11???: op = OP_PORT_IN;
      10'b1111?0????: op = OP_A_FROM_REG;
      10'b1101?11???: op = OP_PORT_AND;
      10'b0010?11???: op = OP_PORT_OUT;
      10'b0010?0????: op = OP_REG_FROM_A;
      10'b0011011???: op = OP_PORT_IMM;
      10'b001110????: op = OP_REG_FROM_IMM;
      default: op = OP_NONE;
    endcase
    return op;
  endfunction : nap_decode

  // Port index 0,1,3,4 to slot 0..3; other indices are not ports
  function automatic logic [2:0] nap_port_slot(input logic [2:0] idx);
    logic [2:0] s;
    s = 3'h4;
    unique case (idx)
      3'h0: s = 3'h0;
      3'h1: s = 3'h1;
      3'h3: s = 3'h2;
      3'h4: s = 3'h3;
      default: s = 3'h4;
    endcase
    return s;
  endfunction : nap_port_slot

endpackage : nap_pkg

//--- nap_ifs.sv
// Carriers between the datapath core and its register file and ports.
// Assumes all signals live on the core clock.
`timescale 1ns/1ps
interface nap_rf_if;
  logic [3:0] rd_idx;
  logic [3:0] rd_lo;
  logic [3:0] rd_hi;
  logic [3:0] p0_lo;
  logic [3:0] p0_hi;
  logic [3:0] wr_idx;
  logic [3:0] wd_lo;
  logic [3:0] wd_hi;
  logic we_lo;
  logic we_hi;
  modport core (output rd_idx, wr_idx, wd_lo, wd_hi, we_lo, we_hi,
                input rd_lo, rd_hi, p0_lo, p0_hi);
  modport mem (input rd_idx, wr_idx, wd_lo, wd_hi, we_lo, we_hi,
               output rd_lo, rd_hi, p0_lo, p0_hi);
endinterface : nap_rf_if

interface nap_port_if;
  logic rd_bank;
  logic [2:0] rd_idx;
  logic [3:0] rd_data;
  logic [2:0] wr_idx;
  logic [3:0] wd_lo;
  logic [3:0] wd_hi;
  logic we_lo;
  logic we_hi;
  modport core (output rd_bank, rd_idx, wr_idx, wd_lo, wd_hi, we_lo, we_hi,
                input rd_data);
  modport io (input rd_bank, rd_idx, wr_idx, wd_lo, wd_hi, we_lo, we_hi,
              output rd_data);
endinterface : nap_port_if

//--- nap_regfile.sv
// Two banks of sixteen scratch nibbles with registered read data.
// Assumes the core presents read and write requests on the same clock.
`timescale 1ns/1ps
module nap_regfile import nap_pkg::*; #(
  parameter int DEPTH = NUM_REGS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Core side
  nap_rf_if.mem rf
);

  logic [3:0] lo_r [DEPTH];
  logic [3:0] hi_r [DEPTH];
  logic [3:0] lo_nxt [DEPTH];
  logic [3:0] hi_nxt [DEPTH];
  logic [3:0] rd_lo_r, rd_hi_r, p0_lo_r, p0_hi_r;

  // ----------------------------------------------------------------
  // Next contents
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      lo_nxt[i] = lo_r[i];
      hi_nxt[i] = hi_r[i];
    end
    if (rf.we_lo) begin
      lo_nxt[rf.wr_idx] = rf.wd_lo;
    end
    if (rf.we_hi) begin
      hi_nxt[rf.wr_idx] = rf.wd_hi;
    end
  end

  // Reads see this cycle's write so pair 0 never lags a store
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      for (int i = 0; i < DEPTH; i++) begin
        lo_r[i] <= NIB_RST;
        hi_r[i] <= NIB_RST;
      end
      rd_lo_r <= NIB_RST;
      rd_hi_r <= NIB_RST;
      p0_lo_r <= NIB_RST;
      p0_hi_r <= NIB_RST;
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        lo_r[i] <= lo_nxt[i];
        hi_r[i] <= hi_nxt[i];
      end
      rd_lo_r <= lo_nxt[rf.rd_idx];
      rd_hi_r <= hi_nxt[rf.rd_idx];
      p0_lo_r <= lo_nxt[0];
      p0_hi_r <= hi_nxt[0];
    end
  end

  assign rf.rd_lo = rd_lo_r;
  assign rf.rd_hi = rd_hi_r;
  assign rf.p0_lo = p0_lo_r;
  assign rf.p0_hi = p0_hi_r;

endmodule : nap_regfile

//--- nap_ports.sv
// Eight nibble ports: output latches and synchronised pin reads.
// Assumes the pins are asynchronous to the core clock.
`timescale 1ns/1ps
module nap_ports import nap_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Pins
  input wire logic [PORT_BITS-1:0] pins_in,
  output logic [PORT_BITS-1:0] latch_out,
  // Core side
  nap_port_if.io pt
);

  logic [PORT_BITS-1:0] sync1_r, sync2_r, latch_r, latch_nxt;
  logic [3:0] rd_r, rd_nxt;
  logic [2:0] rd_slot, wr_slot;

  // ----------------------------------------------------------------
  // Latches, one generate slice per nibble
  // ----------------------------------------------------------------
  assign wr_slot = nap_port_slot(pt.wr_idx);
  for (genvar g = 0; g < NUM_PORT_SLOTS; g++) begin : g_slot
    localparam logic [2:0] SLOT = 3'(g % 4);
    localparam logic BANK = (g >= 4);
    always_comb begin
      latch_nxt[g*4 +: 4] = latch_r[g*4 +: 4];
      if (wr_slot == SLOT && (BANK ? pt.we_hi : pt.we_lo)) begin
        latch_nxt[g*4 +: 4] = BANK ? pt.wd_hi : pt.wd_lo;
      end
    end
  end

  // Unmapped indices read as zero
  assign rd_slot = nap_port_slot(pt.rd_idx);
  always_comb begin
    rd_nxt = NIB_RST;
    if (!rd_slot[2]) begin
      rd_nxt = sync2_r[{pt.rd_bank, rd_slot[1:0], 2'b00} +: 4];
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      latch_r <= '0;
      rd_r <= NIB_RST;
    end else begin
      sync1_r <= pins_in;
      sync2_r <= sync1_r;
      latch_r <= latch_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign latch_out = latch_r;
  assign pt.rd_data = rd_r;

endmodule : nap_ports

//--- nap_core.sv
// Accumulator logic, port and transfer datapath of a nibble core.
// Assumes a sequencer that issues one undecoded word pair at a time, an
// asynchronous-read program memory, and a page register on this clock.
`timescale 1ns/1ps

module nap_core import nap_pkg::*; #(
  parameter int ROM_AW = ROM_ADDR_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Instruction issue
  input wire logic instr_valid,
  input wire logic [INSTR_W-1:0] instr_word,
  input wire logic [INSTR_W-1:0] instr_word2,
  output logic instr_ready,
  output logic instr_done,
  // Program memory
  input wire logic [1:0] rom_page_ctrl,
  output logic [ROM_AW-1:0] rom_addr,
  input wire logic [INSTR_W-1:0] rom_data,
  // Port pins
  input wire logic [PORT_BITS-1:0] port_pins_in,
  output logic [PORT_BITS-1:0] port_latch,
  // Core state
  output logic [3:0] acc,
  output logic carry_flag,
  output logic internal_reset
);

  // ----------------------------------------------------------------
  // Carriers and submodules
  // ----------------------------------------------------------------
  nap_rf_if rf ();
  nap_port_if pt ();

  nap_regfile #(
    .DEPTH(NUM_REGS)
  ) u_regfile (
    .mclk(mclk),
    .nrst(nrst),
    .rf(rf.mem)
  );

  nap_ports u_ports (
    .mclk(mclk),
    .nrst(nrst),
    .pins_in(port_pins_in),
    .latch_out(port_latch),
    .pt(pt.io)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  nap_state_t state_r, state_nxt;
  nap_op_t op_r, op_nxt;
  logic [INSTR_W-1:0] instr_r, instr_nxt;
  logic [INSTR_W-1:0] imm_r, imm_nxt;
  logic [ROM_AW-1:0] rom_addr_r, rom_addr_nxt;
  logic [3:0] acc_r, acc_nxt;
  logic carry_r, carry_nxt;
  logic ready_r, ready_nxt;
  logic done_r, done_nxt;
  logic irst_r, irst_nxt;

  // ----------------------------------------------------------------
  // Operand selection
  // ----------------------------------------------------------------
  logic [3:0] reg_nib;
  logic [3:0] rom_nib;
  logic [3:0] imm_nib;
  logic [3:0] prt_nib;
  logic [4:0] inc_sum;
  logic [3:0] rot_val;
  logic accept;

  assign accept = (state_r == ST_IDLE) && instr_valid;
  // Bank bit picks the high or low register file
  assign reg_nib = instr_r[BANK_BIT] ? rf.rd_hi : rf.rd_lo;
  assign rom_nib = instr_r[HL_BIT] ? rom_data[3:0] : rom_data[7:4];
  assign imm_nib = imm_r[3:0];
  assign prt_nib = pt.rd_data;
  assign inc_sum = {1'b0, acc_r} + 5'h01;
  assign rot_val = {acc_r[2:0], acc_r[3]};

  // ----------------------------------------------------------------
  // Read addressing
  // ----------------------------------------------------------------
  // Read data are registered, so the index goes out in the accept cycle
  always_comb begin
    rf.rd_idx = instr_r[3:0];
    pt.rd_bank = instr_r[BANK_BIT];
    pt.rd_idx = instr_r[2:0];
    // Idle: index straight from the offered word
    if (state_r == ST_IDLE) begin
      rf.rd_idx = instr_word[3:0];
      pt.rd_bank = instr_word[BANK_BIT];
      pt.rd_idx = instr_word[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Register and port writes
  // ----------------------------------------------------------------
  always_comb begin
    rf.wr_idx = instr_r[3:0];
    rf.wd_lo = acc_r;
    rf.wd_hi = acc_r;
    rf.we_lo = 1'b0;
    rf.we_hi = 1'b0;
    pt.wr_idx = instr_r[2:0];
    pt.wd_lo = acc_r;
    pt.wd_hi = acc_r;
    pt.we_lo = 1'b0;
    pt.we_hi = 1'b0;
    if (state_r == ST_OPER) begin
      unique case (op_r)
        OP_REG_FROM_A: begin
          rf.we_hi = instr_r[BANK_BIT];
          rf.we_lo = !instr_r[BANK_BIT];
        end
        OP_REG_FROM_IMM: begin
          rf.wd_hi = imm_r[7:4];
          rf.wd_lo = imm_r[3:0];
          rf.we_hi = 1'b1;
          rf.we_lo = 1'b1;
        end
        OP_PORT_OUT: begin
          pt.we_hi = instr_r[BANK_BIT];
          pt.we_lo = !instr_r[BANK_BIT];
        end
        OP_PORT_IMM: begin
          pt.wd_hi = imm_r[7:4];
          pt.wd_lo = imm_r[3:0];
          pt.we_hi = 1'b1;
          pt.we_lo = 1'b1;
        end
        default: begin
          // Other operations write nothing
          rf.we_lo = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sequencer and accumulator next values
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    instr_nxt = instr_r;
    imm_nxt = imm_r;
    rom_addr_nxt = rom_addr_r;
    acc_nxt = acc_r;
    // Carry held unless an operation sets it
    carry_nxt = carry_r;
    done_nxt = 1'b0;
    irst_nxt = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (accept) begin
          instr_nxt = instr_word;
          imm_nxt = instr_word2;
          op_nxt = nap_decode(instr_word);
          rom_addr_nxt = ROM_AW'({rom_page_ctrl, rf.p0_hi, rf.p0_lo});
          state_nxt = ST_OPER;
        end
      end
      // Valid during execute is dropped, not queued
      ST_OPER: begin
        done_nxt = 1'b1;
        state_nxt = ST_IDLE;
        unique case (op_r)
          OP_OR_REG: begin
            acc_nxt = acc_r | reg_nib;
            carry_nxt = 1'b0;
          end
          OP_OR_ROM: begin
            acc_nxt = acc_r | rom_nib;
            carry_nxt = 1'b0;
          end
          OP_OR_IMM: begin
            acc_nxt = acc_r | imm_nib;
            carry_nxt = 1'b0;
          end
          OP_XOR_REG: begin
            acc_nxt = acc_r ^ reg_nib;
            carry_nxt = acc_r[3] & reg_nib[3];
          end
          OP_XOR_IMM: begin
            acc_nxt = acc_r ^ imm_nib;
            carry_nxt = acc_r[3] & imm_nib[3];
          end
          OP_XOR_ROM: begin
            // Carry from ROM bit 7 or 3
            acc_nxt = acc_r ^ rom_nib;
            carry_nxt = acc_r[3] & rom_nib[3];
          end
          OP_INC: begin
            // Carry only on wrap to zero
            acc_nxt = inc_sum[3:0];
            carry_nxt = (inc_sum[3:0] == 4'h0);
          end
          OP_ROT: begin
            acc_nxt = rot_val;
            carry_nxt = acc_r[3];
          end
          OP_ROT_ZRST: begin
            if (acc_r == 4'h0) begin
              // Acc and carry kept; only the pulse goes out
              irst_nxt = 1'b1;
            end else begin
              acc_nxt = rot_val;
              carry_nxt = acc_r[3];
            end
          end
          OP_PORT_IN: begin
            acc_nxt = prt_nib;
            carry_nxt = 1'b0;
          end
          OP_PORT_AND: begin
            acc_nxt = acc_r & prt_nib;
            carry_nxt = acc_r[3] & prt_nib[3];
          end
          OP_PORT_OR: begin
            acc_nxt = acc_r | prt_nib;
            carry_nxt = 1'b0;
          end
          OP_PORT_XOR: begin
            acc_nxt = acc_r ^ prt_nib;
            carry_nxt = acc_r[3] & prt_nib[3];
          end
          OP_A_FROM_REG: begin
            acc_nxt = reg_nib;
            carry_nxt = 1'b0;
          end
          OP_A_FROM_ROM: begin
            acc_nxt = rom_nib;
            carry_nxt = 1'b0;
          end
          OP_A_FROM_IMM: begin
            acc_nxt = imm_nib;
            carry_nxt = 1'b0;
          end
          default: begin
            // Writes and unknown codes leave the accumulator alone
            acc_nxt = acc_r;
          end
        endcase
      end
    endcase
    ready_nxt = (state_nxt == ST_IDLE);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Synchronous reset; ready is high from the first edge
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      op_r <= OP_NONE;
      instr_r <= WORD_RST;
      imm_r <= WORD_RST;
      rom_addr_r <= '0;
      acc_r <= ACC_RST;
      carry_r <= CARRY_RST;
      ready_r <= 1'b1;
      done_r <= 1'b0;
      irst_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      instr_r <= instr_nxt;
      imm_r <= imm_nxt;
      rom_addr_r <= rom_addr_nxt;
      acc_r <= acc_nxt;
      carry_r <= carry_nxt;
      ready_r <= ready_nxt;
      done_r <= done_nxt;
      irst_r <= irst_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output comes straight from a register
  assign instr_ready = ready_r;
  assign instr_done = done_r;
  assign rom_addr = rom_addr_r;
  assign acc = acc_r;
  assign carry_flag = carry_r;
  assign internal_reset = irst_r;

endmodule : nap_core

//--- nap_core_checker.sv
// Concurrent checks on the nibble datapath top.
// Assumes a bind onto nap_core, one clock and a synchronous reset.
`timescale 1ns/1ps
module nap_core_checker import nap_pkg::*; #(
  parameter int ROM_AW = ROM_ADDR_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Issue
  input wire logic instr_valid,
  input wire logic [INSTR_W-1:0] instr_word,
  input wire logic [INSTR_W-1:0] instr_word2,
  input wire logic instr_ready,
  input wire logic instr_done,
  // Memory and state
  input wire logic [1:0] rom_page_ctrl,
  input wire logic [ROM_AW-1:0] rom_addr,
  input wire logic [INSTR_W-1:0] rom_data,
  input wire logic [PORT_BITS-1:0] port_latch,
  input wire logic [3:0] acc,
  input wire logic carry_flag,
  input wire logic internal_reset
);
  // ----------------------------------------------
  // Operands held from take to done
  // ----------------------------------------------
  logic [9:0] w_r, v_r, d_r;
  logic [3:0] a_r;
  logic c_r;
  logic tk;
  assign tk = instr_valid && instr_ready;
  // Word is cleared so a stale code never matches after reset
  always_ff @(posedge mclk) begin
    if (!nrst) w_r <= 10'h000;
    else if (tk) w_r <= instr_word;
    if (tk) v_r <= instr_word2;
    if (tk) a_r <= acc;
    if (tk) c_r <= carry_flag;
    if (!instr_ready) d_r <= rom_data;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------------
  // Properties
  // ----------------------------------------------
  or_imm_a: assert property (instr_done && w_r == 10'h3b1 |->
    acc == (a_r | v_r[3:0]) && !carry_flag) else $error("or imm wrong");
  or_rom_a: assert property (instr_done && w_r == 10'h390 |->
    acc == (a_r | d_r[7:4]) && !carry_flag) else $error("or rom wrong");
  xor_imm_a: assert property (instr_done && w_r == 10'h2b1 |->
    acc == (a_r ^ v_r[3:0]) && carry_flag == (a_r[3] & v_r[3])) else $error("xor imm wrong");
  xor_rom_a: assert property (instr_done && w_r == 10'h2b0 |->
    acc == (a_r ^ d_r[3:0]) && carry_flag == (a_r[3] & d_r[3])) else $error("xor rom wrong");
  inc_wrap_a: assert property (instr_done && w_r == 10'h293 |->
    acc == a_r + 4'h1 && carry_flag == (a_r == 4'hf)) else $error("inc wrong");
  rot_left_a: assert property (instr_done && w_r == 10'h3f3 |->
    acc == {a_r[2:0], a_r[3]} && carry_flag == a_r[3]) else $error("rotate wrong");
  zero_rst_a: assert property (instr_done && w_r == 10'h3d3 |->
    internal_reset == (a_r == 4'h0)) else $error("zero reset wrong");
  keep_carry_a: assert property (instr_done && w_r[9:7] == 3'b001 |->
    carry_flag == c_r && acc == a_r) else $error("carry moved");
  port_imm_a: assert property (instr_done && w_r == 10'h0d8 |->
    port_latch[3:0] == v_r[3:0] && port_latch[19:16] == v_r[7:4]) else $error("port pair");
  rom_page_a: assert property (tk |=>
    rom_addr[ROM_AW-1 -: 2] == $past(rom_page_ctrl)) else $error("rom page wrong");
  rom_hold_a: assert property (tk |=> (!instr_ready && !instr_done) ##1
    (instr_ready && instr_done && $stable(rom_addr))) else $error("issue timing wrong");
  latch_hold_a: assert property ($changed(port_latch) |-> instr_done) else
    $error("latch moved");
  cover property (instr_done && w_r == 10'h293 && a_r == 4'hf);
  cover property (internal_reset);
  cover property (instr_done && w_r == 10'h0d8);
endmodule : nap_core_checker

bind nap_core nap_core_checker #(.ROM_AW(ROM_AW)) chk_u (.mclk(mclk), .nrst(nrst),
  .instr_valid(instr_valid), .instr_word(instr_word), .instr_word2(instr_word2),
  .instr_ready(instr_ready), .instr_done(instr_done), .rom_page_ctrl(rom_page_ctrl),
  .rom_addr(rom_addr), .rom_data(rom_data), .port_latch(port_latch), .acc(acc),
  .carry_flag(carry_flag), .internal_reset(internal_reset));

//--- nap_core_tb.sv
// Self-checking bench for the nibble datapath top.
// Assumes results commit one edge after each take.
`timescale 1ns/1ps
module nap_core_tb import nap_pkg::*; ;
  // ----------------------------------------------
  // Signals and model state
  // ----------------------------------------------
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic instr_valid = 1'b0;
  logic [9:0] instr_word = 10'h000;
  logic [9:0] instr_word2 = 10'h000;
  logic [1:0] pg = 2'h0;
  logic [31:0] pins = 32'h0;
  logic instr_ready, instr_done, carry_flag, internal_reset;
  logic [9:0] rom_addr, rom_data;
  logic [31:0] port_latch;
  logic [3:0] acc;
  int bad_count = 0;
  int n_compared = 0;
  int seed = 8078;
  int k;
  logic [3:0] m_a, m_rg [32];
  logic m_c, m_ir;
  logic [31:0] m_lat;
  logic [37:0] q [$];
  logic [37:0] e;
  logic [9:0] bse [21] = '{10'h3b1, 10'h390, 10'h398, 10'h380, 10'h2b1, 10'h293, 10'h290,
    10'h298, 10'h280, 10'h3f3, 10'h3d3, 10'h3f1, 10'h3d0, 10'h3d8, 10'h3c0, 10'h358,
    10'h098, 10'h080, 10'h0d8, 10'h0e0, 10'h000};
  logic [9:0] msk [21] = '{10'h000, 10'h020, 10'h027, 10'h02f, 10'h000, 10'h000, 10'h020,
    10'h027, 10'h02f, 10'h000, 10'h000, 10'h000, 10'h020, 10'h027, 10'h02f, 10'h027,
    10'h027, 10'h02f, 10'h007, 10'h00f, 10'h3ff};
  // Edge cases: wrap, kept carry, pair bypass, zero rotate, bad ports
  logic [9:0] dw [16] = '{10'h3f1, 10'h293, 10'h098, 10'h0d8, 10'h085, 10'h0e0, 10'h3d0,
    10'h3f1, 10'h3d3, 10'h3f1, 10'h3f3, 10'h3d3, 10'h09a, 10'h3dd, 10'h0da, 10'h0dc};
  logic [9:0] dv [16] = '{10'h00f, 10'h000, 10'h000, 10'h0c3, 10'h000, 10'h0a5, 10'h000,
    10'h000, 10'h000, 10'h008, 10'h000, 10'h000, 10'h000, 10'h000, 10'h0ff, 10'h05e};

  function automatic logic [9:0] romw(input logic [9:0] a);
    return {a[1:0], a[9:2] ^ 8'h6d};
  endfunction : romw

  function automatic int slot(input logic [2:0] i);
    case (i)
      3'h0, 3'h1: return int'(i);
      3'h3, 3'h4: return int'(i) - 1;
      default: return -8;
    endcase
  endfunction : slot

  assign rom_data = romw(rom_addr);

  nap_core dut_u (.mclk(mclk), .nrst(nrst), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_word2(instr_word2), .instr_ready(instr_ready),
    .instr_done(instr_done), .rom_page_ctrl(pg), .rom_addr(rom_addr), .rom_data(rom_data),
    .port_pins_in(pins), .port_latch(port_latch), .acc(acc), .carry_flag(carry_flag),
    .internal_reset(internal_reset));

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  // ----------------------------------------------
  // Reference model and driver
  // ----------------------------------------------
  task automatic model(input logic [9:0] w, input logic [9:0] v);
    logic [3:0] x;
    logic [9:0] d;
    logic gp;
    int s;
    d = romw({pg, m_rg[16], m_rg[0]});
    s = slot(w[2:0]) + (w[5] ? 4 : 0);
    gp = w[4:0] == 5'h10 || w[4:3] == 2'b11 || w[5:0] == 6'h31 || !w[4];
    x = m_rg[{w[5], w[3:0]}];
    if (w[4:0] == 5'h10) x = w[5] ? d[3:0] : d[7:4];
    if (w[5:0] == 6'h31) x = v[3:0];
    if (w[4:3] == 2'b11) x = (s < 0) ? 4'h0 : pins[4*s +: 4];
    m_ir = 1'b0;
    if (w == 10'h293) begin
      m_a = m_a + 4'h1;
      m_c = m_a == 4'h0;
    end else if (w == 10'h3f3 || (w == 10'h3d3 && m_a != 4'h0)) begin
      m_c = m_a[3];
      m_a = {m_a[2:0], m_a[3]};
    end else if (w == 10'h3d3) m_ir = 1'b1;
    else if (w[9:6] == 4'he && gp) {m_c, m_a} = {1'b0, m_a | x};
    else if (w[9:6] == 4'ha && gp) {m_c, m_a} = {m_a[3] & x[3], m_a ^ x};
    else if (w[9:6] == 4'hf && gp) {m_c, m_a} = {1'b0, x};
    else if (w[9:6] == 4'hd && w[4:3] == 2'b11) {m_c, m_a} = {m_a[3] & x[3], m_a & x};
    else if (w[9:6] == 4'h2 && w[4:3] == 2'b11 && s >= 0) m_lat[4*s +: 4] = m_a;
    else if (w[9:6] == 4'h2 && !w[4]) m_rg[{w[5], w[3:0]}] = m_a;
    else if (w[9:3] == 7'h1b && s >= 0) begin
      m_lat[4*s +: 4] = v[3:0];
      m_lat[4*s+16 +: 4] = v[7:4];
    end else if (w[9:4] == 6'h0e) {m_rg[{1'b1, w[3:0]}], m_rg[{1'b0, w[3:0]}]} = v[7:0];
    q.push_back({m_ir, m_c, m_a, m_lat});
  endtask : model

  // Hold keeps valid up in the busy cycle with another word
  task automatic issue(input logic [9:0] w, input logic [9:0] v, input logic hold);
    instr_valid <= 1'b1;
    instr_word <= w;
    instr_word2 <= v;
    model(w, v);
    @(posedge mclk);
    if (hold) instr_word <= 10'h293;
    else instr_valid <= 1'b0;
    @(posedge mclk);
    if (hold) begin
      instr_valid <= 1'b0;
      @(posedge mclk);
    end
  endtask : issue

  task automatic do_reset;
    nrst <= 1'b0;
    instr_valid <= 1'b0;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    {m_a, m_c, m_lat} = 37'h0;
    m_rg = '{default: 4'h0};
    q.delete();
    @(posedge mclk);
  endtask : do_reset

  // Pins settle three edges before any read
  task automatic new_pins;
    k = $random(seed);
    pins <= $random(seed);
    pg <= k[1:0];
    repeat (3) @(posedge mclk);
  endtask : new_pins

  task automatic wrap_up;
    if (q.size() != 0) bad_count++;
    $display("TB: compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // ----------------------------------------------
  // Result monitor and watchdog
  // ----------------------------------------------
  always @(negedge mclk) begin
    if (instr_done === 1'b1) begin
      e = (q.size() != 0) ? q.pop_front() : ~{internal_reset, carry_flag, acc, port_latch};
      n_compared++;
      if ({internal_reset, carry_flag, acc, port_latch} !== e) begin
        bad_count++;
        $display("BAD t=%0t got %h exp %h", $time,
          {internal_reset, carry_flag, acc, port_latch}, e);
      end
    end
  end

  initial begin
    #100000;
    bad_count++;
    wrap_up;
  end

  // ----------------------------------------------
  // Tests
  // ----------------------------------------------
  initial begin
    do_reset;
    for (int n = 0; n < 8; n++) begin
      new_pins;
      for (int i = 0; i < 21; i++) begin
        k = $random(seed);
        issue(bse[i] | (k[9:0] & msk[i]), k[19:10], 1'b0);
      end
    end
    $display("TB: test all groups ended");
    for (int i = 0; i < 16; i++) issue(dw[i], dv[i], 1'b0);
    $display("TB: test edge cases ended");
    issue(10'h3f1, 10'h005, 1'b1);
    issue(10'h000, 10'h000, 1'b0);
    $display("TB: test refused word ended");
    instr_word <= 10'h293;
    instr_valid <= 1'b1;
    @(posedge mclk);
    do_reset;
    k = $random(seed);
    issue(10'h3c0 | (k[9:0] & 10'h02f), 10'h000, 1'b0);
    issue(10'h000, 10'h000, 1'b0);
    $display("TB: test mid-run reset ended");
    repeat (3) @(posedge mclk);
    wrap_up;
  end
endmodule : nap_core_tb
